// *** accel_cap_params.svh ***
/*
 * Offsets, field positions and fixed values of the capability register bank.
 * Assumes byte addresses within the device's memory window, 8-byte words.
 */
`ifndef ACCEL_CAP_PARAMS_SVH
`define ACCEL_CAP_PARAMS_SVH

`define CAP_ADDR_W 12
`define GROUP_CAP_OFFSET 12'h030
`define ENGINE_CAP_OFFSET 12'h038
`define OP_CAP_OFFSET 12'h040
`define OP_CAP_LAST_OFFSET 12'h058
`define OP_CAP_WORDS 4
`define OP_CAP_BITS 256
`define WORD_BITS 64

`define GRP_BW_LIMIT_BIT 19
`define GRP_DIP_LIMIT_BIT 18
`define GRP_GLOBAL_RB_BIT 17
`define GRP_RB_CTRL_BIT 16
`define GRP_TOTAL_RB_MSB 15
`define GRP_TOTAL_RB_LSB 8
`define GRP_COUNT_MSB 7
`define GRP_COUNT_LSB 0
`define GRP_USED_BITS 20

`define ENG_MAX_BATCH_MSB 23
`define ENG_MAX_BATCH_LSB 16
`define ENG_MAX_WORK_MSB 15
`define ENG_MAX_WORK_LSB 8
`define ENG_COUNT_MSB 7
`define ENG_COUNT_LSB 0
`define ENG_USED_BITS 24

`define CAP_WORD_ZERO 64'h0000_0000_0000_0000
`define CAP_BYTE_ZERO 8'h00

`endif

// *** accel_cap_pkg.sv ***
/*
 * Types shared by the capability register bank.
 * Assumes accel_cap_params.svh is on the include path.
 */
`include "accel_cap_params.svh"

package accel_cap_pkg;
    typedef logic [`WORD_BITS-1:0] cap_word_type;
    typedef logic [`CAP_ADDR_W-1:0] cap_addr_type;
    typedef logic [`OP_CAP_BITS-1:0] op_mask_type;
    typedef enum logic {RESP_IDLE, RESP_VALID} resp_state_type;
endpackage

// *** cap_image_if.sv ***
/*
 * Carries the assembled capability image from the bank to its word selector.
 * Assumes one producer and one consumer inside the same clock domain.
 */
`timescale 1ns/100ps

interface cap_image_if;
    import accel_cap_pkg::*;
    cap_word_type group_word;
    cap_word_type engine_word;
    op_mask_type op_mask;

    modport producer(output group_word, output engine_word, output op_mask);
    modport consumer(input group_word, input engine_word, input op_mask);
endinterface

// *** cap_word_select.sv ***
/*
 * Combinational address decode and word select over the capability image.
 * Assumes 8-byte aligned accesses; anything else misses and reads zero.
 */
`timescale 1ns/100ps
`include "accel_cap_params.svh"

module cap_word_select (
    input wire accel_cap_pkg::cap_addr_type i_addr,
    cap_image_if.consumer image,
    output logic [`WORD_BITS-1:0] o_word,
    output logic o_hit
);
    import accel_cap_pkg::*;

    always_comb begin
        o_word = `CAP_WORD_ZERO;
        o_hit = 1'b0;
        if (i_addr[2:0] == 3'h0) begin
            if (i_addr == `GROUP_CAP_OFFSET) begin
                o_word = image.group_word;
                o_hit = 1'b1;
            end else if (i_addr == `ENGINE_CAP_OFFSET) begin
                o_word = image.engine_word;
                o_hit = 1'b1;
            end else if (i_addr >= `OP_CAP_OFFSET && i_addr <= `OP_CAP_LAST_OFFSET) begin
                // qword k of the 256-bit mask, low word at the lowest address
                o_word = image.op_mask[i_addr[4:3]*`WORD_BITS +: `WORD_BITS];
                o_hit = 1'b1;
            end
        end
    end
endmodule // cap_word_select

// *** accel_capability_registers.sv ***
/*
 * Read-only capability register bank: group, engine and operation capabilities.
 * Assumes a simple memory-mapped request port, one 64-bit word per request,
 * synchronous to i_clk; the answer comes one cycle after the request.
 */
//
// Overview of operation
// R1: group bit 19 reports bandwidth limit support for per-engine group limits.
// R2: group bit 18 reports descriptors-in-progress limit support per engine.
// R3: group bit 17 reports global read-buffer limit support.
// R4: group bit 16 reports read-buffer controls; without it total count undefined.
// R5: group bits 15:8 total read buffers, bits 7:0 group count.
// R6: engine bits 23:16 give maximum batch descriptors in progress per engine.
// R7: engine bits 15:8 maximum work descriptors, bits 7:0 engine count.
// R8: both descriptor maxima undefined while group bit 18 reads zero.
// R9: operation mask is 256 bits, bit n for operation code n.
// R10: mask bit one means supported; undefined codes always read zero.
// R11: group at 0x30, engine at 0x38, operations 32 bytes at 0x40, read-only.
// R12: writes have no effect; values stay constant after reset.
`timescale 1ns/100ps
`include "accel_cap_params.svh"

module accel_capability_registers #(
    parameter logic BW_LIMIT_SUPPORT = 1'b1,
    parameter logic DIP_LIMIT_SUPPORT = 1'b1,
    parameter logic GLOBAL_RB_SUPPORT = 1'b1,
    parameter logic RB_CTRL_SUPPORT = 1'b1,
    parameter logic [7:0] TOTAL_READ_BUFFERS = 8'h20,
    parameter logic [7:0] NUM_GROUPS = 8'h04,
    parameter logic [7:0] MAX_BATCH_IN_PROGRESS = 8'h04,
    parameter logic [7:0] MAX_WORK_IN_PROGRESS = 8'h10,
    parameter logic [7:0] NUM_ENGINES = 8'h04,
    parameter logic [`OP_CAP_BITS-1:0] OPS_SUPPORTED = {{(`OP_CAP_BITS-4){1'b0}}, 4'hf},
    parameter logic [`OP_CAP_BITS-1:0] OPS_DEFINED = {{(`OP_CAP_BITS-4){1'b0}}, 4'hf}
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_mmio_req,
    input wire logic i_mmio_write,
    input wire accel_cap_pkg::cap_addr_type i_mmio_addr,
    input wire accel_cap_pkg::cap_word_type i_mmio_wdata,
    output logic o_mmio_ack,
    output logic o_mmio_hit,
    output accel_cap_pkg::cap_word_type o_mmio_rdata
);
    import accel_cap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // refused while building, so a bank with no groups or engines never exists
    if (NUM_GROUPS == `CAP_BYTE_ZERO || NUM_ENGINES == `CAP_BYTE_ZERO) begin : g_bad_counts
        $error("group and engine counts must be nonzero");
    end
    if (DIP_LIMIT_SUPPORT && (MAX_WORK_IN_PROGRESS == `CAP_BYTE_ZERO)) begin : g_bad_work
        $error("work descriptors in progress must be nonzero");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capability image, fixed by parameters

    cap_image_if image ();

    always_comb begin
        image.group_word = `CAP_WORD_ZERO;
        image.group_word[`GRP_BW_LIMIT_BIT] = BW_LIMIT_SUPPORT; // R1
        image.group_word[`GRP_DIP_LIMIT_BIT] = DIP_LIMIT_SUPPORT; // R2
        image.group_word[`GRP_GLOBAL_RB_BIT] = GLOBAL_RB_SUPPORT; // R3
        image.group_word[`GRP_RB_CTRL_BIT] = RB_CTRL_SUPPORT; // R4
        // undefined count shown as zero so software cannot mistake it for a value
        image.group_word[`GRP_TOTAL_RB_MSB:`GRP_TOTAL_RB_LSB] =
            RB_CTRL_SUPPORT ? TOTAL_READ_BUFFERS : `CAP_BYTE_ZERO; // R4 R5
        image.group_word[`GRP_COUNT_MSB:`GRP_COUNT_LSB] = NUM_GROUPS; // R5

        image.engine_word = `CAP_WORD_ZERO;
        if (DIP_LIMIT_SUPPORT) begin // R8
            image.engine_word[`ENG_MAX_BATCH_MSB:`ENG_MAX_BATCH_LSB] =
                MAX_BATCH_IN_PROGRESS; // R6
            image.engine_word[`ENG_MAX_WORK_MSB:`ENG_MAX_WORK_LSB] =
                MAX_WORK_IN_PROGRESS; // R7
        end
        image.engine_word[`ENG_COUNT_MSB:`ENG_COUNT_LSB] = NUM_ENGINES; // R7

        image.op_mask = OPS_SUPPORTED & OPS_DEFINED; // R9 R10
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request decode and registered answer

    logic [`WORD_BITS-1:0] sel_word;
    logic sel_hit;

    cap_word_select u_select (
        .i_addr(i_mmio_addr),
        .image(image),
        .o_word(sel_word),
        .o_hit(sel_hit)
    ); // R11

    resp_state_type state_reg, state_next;
    cap_word_type rdata_reg, rdata_next;
    logic hit_reg, hit_next;

    always_comb begin
        state_next = i_mmio_req ? RESP_VALID : RESP_IDLE;
        hit_next = i_mmio_req && sel_hit;
        rdata_next = `CAP_WORD_ZERO;
        // writes are acknowledged and dropped; write data never reaches state
        if (i_mmio_req && !i_mmio_write) begin // R12
            rdata_next = sel_word; // R11
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= RESP_IDLE;
            rdata_reg <= `CAP_WORD_ZERO;
            hit_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            hit_reg <= hit_next;
        end
    end

    assign o_mmio_ack = (state_reg == RESP_VALID);
    assign o_mmio_hit = hit_reg;
    assign o_mmio_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    logic unused_wdata;
    assign unused_wdata = ^i_mmio_wdata;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    sequence s_read(cap_addr_type a);
        i_mmio_req && !i_mmio_write && i_mmio_addr == a;
    endsequence

    sequence s_write;
        i_mmio_req && i_mmio_write;
    endsequence

    property p_ack_one_cycle;
        i_mmio_req |=> o_mmio_ack ##0 (!o_mmio_ack || $past(i_mmio_req));
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack not one cycle after request"); // R11

    property p_idle_quiet;
        !i_mmio_req |=> !o_mmio_ack && !o_mmio_hit && o_mmio_rdata == `CAP_WORD_ZERO;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("answer without a request"); // R11

    property p_group_flags;
        s_read(`GROUP_CAP_OFFSET) |=> o_mmio_hit
            && o_mmio_rdata[`GRP_BW_LIMIT_BIT] == BW_LIMIT_SUPPORT
            && o_mmio_rdata[`GRP_DIP_LIMIT_BIT] == DIP_LIMIT_SUPPORT
            && o_mmio_rdata[`GRP_GLOBAL_RB_BIT] == GLOBAL_RB_SUPPORT;
    endproperty
    a_group_flags: assert property (p_group_flags) else $error("group flag bits wrong"); // R1 R2 R3

    property p_group_counts;
        s_read(`GROUP_CAP_OFFSET) |=>
            o_mmio_rdata[`GRP_COUNT_MSB:`GRP_COUNT_LSB] == NUM_GROUPS
            && o_mmio_rdata[`WORD_BITS-1:`GRP_USED_BITS] == '0;
    endproperty
    a_group_counts: assert property (p_group_counts) else $error("group count wrong"); // R5

    property p_read_buffers;
        s_read(`GROUP_CAP_OFFSET) |=> o_mmio_rdata[`GRP_RB_CTRL_BIT] == RB_CTRL_SUPPORT
            && (!RB_CTRL_SUPPORT
                || o_mmio_rdata[`GRP_TOTAL_RB_MSB:`GRP_TOTAL_RB_LSB] == TOTAL_READ_BUFFERS);
    endproperty
    a_read_buffers: assert property (p_read_buffers) else $error("read buffer fields wrong"); // R4

    property p_engine_limits;
        s_read(`ENGINE_CAP_OFFSET) |=> o_mmio_hit
            && o_mmio_rdata[`ENG_COUNT_MSB:`ENG_COUNT_LSB] == NUM_ENGINES
            && o_mmio_rdata[`WORD_BITS-1:`ENG_USED_BITS] == '0
            && (!DIP_LIMIT_SUPPORT
                || (o_mmio_rdata[`ENG_MAX_BATCH_MSB:`ENG_MAX_BATCH_LSB] == MAX_BATCH_IN_PROGRESS
                && o_mmio_rdata[`ENG_MAX_WORK_MSB:`ENG_MAX_WORK_LSB] == MAX_WORK_IN_PROGRESS));
    endproperty
    a_engine_limits: assert property (p_engine_limits) else $error("engine fields wrong"); // R6 R7 R8

    property p_dip_maxima_zero;
        s_read(`ENGINE_CAP_OFFSET) |=> DIP_LIMIT_SUPPORT
            || o_mmio_rdata[`ENG_MAX_BATCH_MSB:`ENG_MAX_WORK_LSB] == 16'h0000;
    endproperty
    a_dip_maxima_zero: assert property (p_dip_maxima_zero) else $error("maxima not zero"); // R8

    // aligned read of one of the four mask words
    sequence s_op_read;
        i_mmio_req && !i_mmio_write && i_mmio_addr[2:0] == 3'h0
            && i_mmio_addr >= `OP_CAP_OFFSET && i_mmio_addr <= `OP_CAP_LAST_OFFSET;
    endsequence

    // only the addressed 64 bits of the shifted mask are compared
    property p_op_mask;
        s_op_read |=> o_mmio_hit && o_mmio_rdata == cap_word_type'(
            (OPS_SUPPORTED & OPS_DEFINED) >> ($past(i_mmio_addr[4:3]) * `WORD_BITS));
    endproperty
    a_op_mask: assert property (p_op_mask) else $error("operation mask word wrong"); // R9 R10

    // a code claimed as supported but left undefined must still read zero
    property p_undef_ops_zero;
        s_op_read |=> (o_mmio_rdata & ~cap_word_type'(
            OPS_DEFINED >> ($past(i_mmio_addr[4:3]) * `WORD_BITS))) == `CAP_WORD_ZERO;
    endproperty
    a_undef_ops_zero: assert property (p_undef_ops_zero) else $error("undefined op set"); // R10

    property p_write_ignored;
        s_write |=> o_mmio_ack && o_mmio_rdata == `CAP_WORD_ZERO ##1 $stable(image.group_word)
            && $stable(image.engine_word) && $stable(image.op_mask);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed the bank"); // R12

    property p_write_hit;
        s_write ##0 (i_mmio_addr == `GROUP_CAP_OFFSET) |=> o_mmio_ack && o_mmio_hit;
    endproperty
    a_write_hit: assert property (p_write_hit) else $error("write to a mapped word missed"); // R12

    property p_unmapped_zero;
        (i_mmio_req && !sel_hit) |=> !o_mmio_hit && o_mmio_rdata == `CAP_WORD_ZERO;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // R11
endmodule // accel_capability_registers

// *** accelerator_capability_registers_tb.sv ***
/*
 * Self-checking bench for the capability register bank: two banks with
 * different capability parameters share one request port.
 * Assumes the design files and accel_cap_params.svh are compiled first.
 */
`timescale 1ns/100ps
`include "accel_cap_params.svh"

module accelerator_capability_registers_tb;
    import accel_cap_pkg::*;
    // bank b: codes 0, 130 and 200 claimed, but 200 is left undefined
    localparam op_mask_type OPS_B = (256'h1 << 200) | (256'h1 << 130) | 256'h1;
    localparam op_mask_type DEF_B = (256'h1 << 255) | (256'h1 << 130) | 256'h1;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_mmio_req = 1'b0;
    logic i_mmio_write = 1'b0;
    cap_addr_type i_mmio_addr = 12'h000;
    cap_word_type i_mmio_wdata = 64'h0;
    logic ack [2];
    logic hit [2];
    cap_word_type rd [2];
    int num_errors = 0;
    int checks_done = 0;
    // words at 0x30, 0x38, then the four operation mask words
    cap_word_type exp_w [2][6] = '{
        '{64'h0000_0000_000f_2004, 64'h0000_0000_0004_1004, 64'hf, 64'h0, 64'h0, 64'h0},
        '{64'h0000_0000_000a_0004, 64'h0000_0000_0000_0004, 64'h1, 64'h0, 64'h4, 64'h0}};

    accel_capability_registers i_accel_capability_registers (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_mmio_req(i_mmio_req),
        .i_mmio_write(i_mmio_write), .i_mmio_addr(i_mmio_addr), .i_mmio_wdata(i_mmio_wdata),
        .o_mmio_ack(ack[0]), .o_mmio_hit(hit[0]), .o_mmio_rdata(rd[0]));
    accel_capability_registers #(
        .BW_LIMIT_SUPPORT(1'b1), .DIP_LIMIT_SUPPORT(1'b0), .GLOBAL_RB_SUPPORT(1'b1),
        .RB_CTRL_SUPPORT(1'b0), .OPS_SUPPORTED(OPS_B), .OPS_DEFINED(DEF_B)
    ) i_accel_capability_registers_b (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_mmio_req(i_mmio_req),
        .i_mmio_write(i_mmio_write), .i_mmio_addr(i_mmio_addr), .i_mmio_wdata(i_mmio_wdata),
        .o_mmio_ack(ack[1]), .o_mmio_hit(hit[1]), .o_mmio_rdata(rd[1]));

    always #12.5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input cap_word_type got, input cap_word_type exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_ans(input int b, input logic h, input cap_word_type d);
        chk({63'h0, ack[b]}, 64'h1, "ack");
        chk({63'h0, hit[b]}, {63'h0, h}, "hit");
        chk(rd[b], d, "rdata");
    endtask

    // idle cycle, then a one-cycle request pulse; caller stands just after a rising edge
    // the idle cycle keeps the request line from being lowered and raised at one instant
    task automatic access(input logic wr, input cap_addr_type a);
        @(posedge i_clk);
        #1;
        i_mmio_req = 1'b1;
        i_mmio_write = wr;
        i_mmio_addr = a;
        @(posedge i_clk);
        #1;
        i_mmio_req = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (15) @(posedge i_clk);
        #1;
        for (int b = 0; b < 2; b++) begin
            chk({62'h0, ack[b], hit[b]}, 64'h0, "reset flags");
            chk(rd[b], 64'h0, "reset rdata");
        end
        @(posedge i_clk);
        #1;
        i_arst_n = 1'b1;
        $display("test reset done");
    endtask

    task automatic t_read_map();
        for (int k = 0; k < 6; k++) begin
            access(1'b0, `GROUP_CAP_OFFSET + 12'(8 * k));
            for (int b = 0; b < 2; b++) chk_ans(b, 1'b1, exp_w[b][k]);
        end
        $display("test read map done");
    endtask

    task automatic t_writes();
        i_mmio_wdata = 64'hffff_ffff_ffff_ffff;
        for (int k = 0; k < 6; k++) begin
            access(1'b1, `GROUP_CAP_OFFSET + 12'(8 * k));
            for (int b = 0; b < 2; b++) chk_ans(b, 1'b1, 64'h0);
        end
        for (int k = 0; k < 6; k++) begin
            access(1'b0, `GROUP_CAP_OFFSET + 12'(8 * k));
            for (int b = 0; b < 2; b++) chk_ans(b, 1'b1, exp_w[b][k]);
        end
        $display("test writes done");
    endtask

    task automatic t_misses();
        cap_addr_type miss [4] = '{12'h034, 12'h028, 12'h060, 12'hfff};
        for (int m = 0; m < 4; m++) begin
            access(1'b0, miss[m]);
            for (int b = 0; b < 2; b++) chk_ans(b, 1'b0, 64'h0);
        end
        $display("test misses done");
    endtask

    // request held high: one answer per cycle, each for the previous address
    task automatic t_back_to_back();
        @(posedge i_clk);
        #1;
        i_mmio_req = 1'b1;
        i_mmio_write = 1'b0;
        i_mmio_addr = `GROUP_CAP_OFFSET;
        @(posedge i_clk);
        #1;
        i_mmio_addr = `OP_CAP_LAST_OFFSET;
        for (int b = 0; b < 2; b++) chk_ans(b, 1'b1, exp_w[b][0]);
        @(posedge i_clk);
        #1;
        i_mmio_req = 1'b0;
        for (int b = 0; b < 2; b++) chk_ans(b, 1'b1, exp_w[b][5]);
        @(posedge i_clk);
        #1;
        chk({63'h0, ack[0]}, 64'h0, "ack after pulse");
        $display("test back to back done");
    endtask

    initial begin
        t_reset();
        t_read_map();
        t_writes();
        t_misses();
        t_back_to_back();
        wrap_up();
    end

    initial begin
        #(25 * 2000);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule // accelerator_capability_registers_tb
